// File: pkg/rtsm_pkg.sv
/*
 * Constants for the radio test signal mux: register map, field
 * positions, reset values, select codes and synchroniser indices.
 * Assumes a single 50 MHz clock domain and a plain register port.
 */
package rtsm_pkg;

	// ==========================================================
	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int SEL_W  = 5;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] REG_PIN_CFG  = 8'h00;  // pin_config_reg_b
	localparam logic [7:0] REG_PIN_STAT = 8'h04;  // live pin and source levels

	// ==========================================================
	// field positions and reset values
	localparam int CHAN_SEL_LSB  = 0;   // chan_pin_test_select
	localparam int FRAME_SEL_LSB = 5;   // frame_pin_test_select
	localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
	localparam logic [DATA_W-1:0] RD_IDLE  = 16'h0000;

	// ==========================================================
	// select codes shared by both pins or specific to one
	localparam logic [SEL_W-1:0] SEL_NORMAL   = 5'h00;
	localparam logic [SEL_W-1:0] SEL_ADC_LSB  = 5'h01;
	localparam logic [SEL_W-1:0] SEL_RESYNC   = 5'h02;
	localparam logic [SEL_W-1:0] SEL_LOCK     = 5'h03;
	localparam logic [SEL_W-1:0] SEL_TX_FAST  = 5'h04;
	localparam logic [SEL_W-1:0] SEL_TX_SLOW  = 5'h05;
	localparam logic [SEL_W-1:0] SEL_PD_FIRST = 5'h06;
	localparam logic [SEL_W-1:0] SEL_PD_LAST  = 5'h0B;
	localparam logic [SEL_W-1:0] SEL_C12      = 5'h0C;
	localparam logic [SEL_W-1:0] SEL_C13      = 5'h0D;
	localparam logic [SEL_W-1:0] SEL_C14      = 5'h0E;
	localparam logic [SEL_W-1:0] SEL_C15      = 5'h0F;
	localparam logic [SEL_W-1:0] SEL_C16      = 5'h10;
	localparam logic [SEL_W-1:0] SEL_C17      = 5'h11;
	localparam logic [SEL_W-1:0] SEL_CLK8     = 5'h17;
	localparam logic [SEL_W-1:0] SEL_C24      = 5'h18;
	localparam logic [SEL_W-1:0] SEL_REF      = 5'h19;
	localparam logic [SEL_W-1:0] SEL_DIV      = 5'h1A;
	localparam logic [SEL_W-1:0] SEL_WIN      = 5'h1B;
	localparam logic [SEL_W-1:0] SEL_WIN_SYNC = 5'h1C;
	localparam logic [SEL_W-1:0] SEL_ADC_CLK  = 5'h1D;
	localparam logic [SEL_W-1:0] SEL_LOW      = 5'h1E;
	localparam logic [SEL_W-1:0] SEL_HIGH     = 5'h1F;

	// ==========================================================
	// widths of grouped sources
	localparam int PD_W   = 6;
	localparam int PEAK_W = 5;

	// ==========================================================
	// indices into the synchronised foreign-clock sources
	localparam int SYNC_CHIP_CLK = 0;
	localparam int SYNC_BIT_CLK  = 1;
	localparam int SYNC_CAL_CLK  = 2;
	localparam int SYNC_CLK8     = 3;
	localparam int SYNC_REF      = 4;
	localparam int SYNC_DIV      = 5;
	localparam int SYNC_ADC_ONE  = 6;
	localparam int SYNC_ADC_TWO  = 7;
	localparam int SYNC_W        = 8;

	// synchroniser reset level
	localparam logic SYNC_RESET = 1'b0;

endpackage

// File: src/rtsm_sync.sv
/*
 * Two-flop level synchroniser, one lane per bit.
 * Assumes the inputs are levels from foreign clocks or pins.
 */
`timescale 1ns/10ps
module rtsm_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,      // system clock
	input  wire logic             sys_rst,  // synchronous reset, high
	input  wire logic [WIDTH-1:0] asyncIn,  // foreign-domain levels
	output logic      [WIDTH-1:0] syncOut   // levels in clk domain
);

	// ==========================================================
	// per-bit two-stage chain; first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gLane
			logic stage1;
			logic stage2;
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					stage1 <= rtsm_pkg::SYNC_RESET;
					stage2 <= rtsm_pkg::SYNC_RESET;
				end else begin
					stage1 <= asyncIn[i];
					stage2 <= stage1;
				end
			end
			assign syncOut[i] = stage2;
		end
	endgenerate

endmodule

// File: src/rtsm_mux.sv
/*
 * Test signal mux for the two status output pins: register port for
 * the pin select fields and the two registered output multiplexers.
 * Assumes same-clock radio logic drives the plain sources, and that
 * clock-like sources arrive from other domains and are synchronised.
 */
// Summary of operation
// RULE1 - each pin picks normal or test source
// RULE2 - channel pin select 1: ADC Q lsb
// RULE3 - frame pin select 1: ADC I lsb
// RULE4 - channel select 2: late resync pulse
// RULE5 - frame select 2: early resync pulse
// RULE6 - select 3 outputs synthesizer lock status
// RULE7 - channel 4/5: chip, bit clock in transmit
// RULE8 - frame 4/5: chip, bit data in transmit
// RULE9 - selects 6..11 output power-down controls
// RULE10 - channel select 12: gain update pulse
// RULE11 - channel 13..16: peak 1,3, gainmode1, vga1
// RULE12 - frame 12..16: peak 0,2,4, gainmode0, vga0
// RULE13 - channel 17: peak-detector reset, low active
// RULE14 - frame 17: filter calibration clock
// RULE15 - channel 23: 8 MHz clock
// RULE16 - channel 24: crystal stable indication
// RULE17 - frame 24: frequency comparator value
// RULE18 - selects 25, 26: reference, divided signal
// RULE19 - selects 27, 28: lock window, synced window
// RULE20 - 30 low, 31 high, 29 ADC clock
// RULE21 - five-bit selects, reserved codes drive low
`timescale 1ns/10ps
module rtsm_mux (
	input  wire logic                          clk,                   // 50 MHz
	input  wire logic                          sys_rst,               // sync reset
	input  wire logic [rtsm_pkg::ADDR_W-1:0]   regAddr,               // byte address
	input  wire logic [rtsm_pkg::DATA_W-1:0]   regWrData,             // write data
	input  wire logic                          regWr,                 // write strobe
	input  wire logic                          regRd,                 // read strobe
	output logic      [rtsm_pkg::DATA_W-1:0]   regRdData,             // read data
	input  wire logic                          clearChannelNormal,    // normal indication
	input  wire logic                          frameStartNormal,      // normal indication
	input  wire logic                          adcQLsb,               // ADC Q bit 0
	input  wire logic                          adcILsb,               // ADC I bit 0
	input  wire logic                          pulseA,                // late resync event
	input  wire logic                          demodResyncEarlyPulse, // early resync event
	input  wire logic                          lockStatus,            // synth lock
	input  wire logic                          txActive,              // transmitting
	input  wire logic                          txChipData,            // chip-rate data
	input  wire logic                          txBitData,             // bit-rate data
	input  wire logic [rtsm_pkg::PD_W-1:0]     powerDown,             // fs,adc,vga,bpf,lna,pa
	input  wire logic                          gainUpdatePulse,       // AGC changed gain
	input  wire logic [rtsm_pkg::PEAK_W-1:0]   peakDetect,            // peak stages
	input  wire logic [1:0]                    gainMode,              // front-end gain
	input  wire logic [1:0]                    vgaGain,               // VGA gain bits
	input  wire logic                          vgaPeakReset_n,        // peak reset, low
	input  wire logic                          crystalStable,         // oscillator ok
	input  wire logic                          synthFreqCompare,      // comparator
	input  wire logic                          synthLockWindow,       // lock window
	input  wire logic                          synthLockWindowSync,   // synced window
	input  wire logic                          txChipClock,           // foreign clock
	input  wire logic                          txBitClock,            // foreign clock
	input  wire logic                          rxFilterCalClock,      // foreign clock
	input  wire logic                          clock8mhz,             // foreign clock
	input  wire logic                          synthRef4mhz,          // foreign clock
	input  wire logic                          synthDiv4mhz,          // foreign clock
	input  wire logic                          adcClockOne,           // foreign clock
	input  wire logic                          adcClockTwo,           // foreign clock
	output logic                               clearChannelOut,       // channel pin
	output logic                               frameStartOut          // frame pin
);

	// ==========================================================
	// state
	logic [rtsm_pkg::SEL_W-1:0]  chanPinTestSelect;
	logic [rtsm_pkg::SEL_W-1:0]  framePinTestSelect;
	logic [rtsm_pkg::SYNC_W-1:0] rawClocks;
	logic [rtsm_pkg::SYNC_W-1:0] syncClocks;
	logic                        next_clearChannelOut;
	logic                        next_frameStartOut;
	logic                        cfgHit;
	logic                        statHit;

	// ==========================================================
	// foreign clocks are only levels here, so two flops suffice;
	// they reach the pins two cycles later than same-clock sources
	assign rawClocks = {adcClockTwo, adcClockOne, synthDiv4mhz, synthRef4mhz,
		clock8mhz, rxFilterCalClock, txBitClock, txChipClock};

	rtsm_sync #(
		.WIDTH (rtsm_pkg::SYNC_W)
	) uSync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.asyncIn (rawClocks),
		.syncOut (syncClocks)
	);

	// ==========================================================
	// codes whose meaning is the same on both pins
	function automatic logic commonSource(
		input logic [rtsm_pkg::SEL_W-1:0]  sel,
		input logic [rtsm_pkg::SYNC_W-1:0] clks
	);
		logic [2:0] pdIdx;
		logic       res;
		pdIdx = 3'(sel - rtsm_pkg::SEL_PD_FIRST);
		res   = 1'b0;
		// RULE6 lock status
		if (sel == rtsm_pkg::SEL_LOCK) begin
			res = lockStatus;
		// RULE9 power-down controls
		end else if (sel >= rtsm_pkg::SEL_PD_FIRST && sel <= rtsm_pkg::SEL_PD_LAST) begin
			res = powerDown[pdIdx];
		// RULE18 synthesizer reference and divided
		end else if (sel == rtsm_pkg::SEL_REF) begin
			res = clks[rtsm_pkg::SYNC_REF];
		end else if (sel == rtsm_pkg::SEL_DIV) begin
			res = clks[rtsm_pkg::SYNC_DIV];
		// RULE19 lock windows
		end else if (sel == rtsm_pkg::SEL_WIN) begin
			res = synthLockWindow;
		end else if (sel == rtsm_pkg::SEL_WIN_SYNC) begin
			res = synthLockWindowSync;
		// RULE20 constant high; low falls to the default
		end else if (sel == rtsm_pkg::SEL_HIGH) begin
			res = 1'b1;
		end
		return res;
	endfunction

	// ==========================================================
	// register decode
	assign cfgHit  = (regAddr == rtsm_pkg::REG_PIN_CFG);
	assign statHit = (regAddr == rtsm_pkg::REG_PIN_STAT);

	// RULE1 separate select per pin
	// RULE21 five-bit select fields
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chanPinTestSelect  <= rtsm_pkg::SEL_RESET;
			framePinTestSelect <= rtsm_pkg::SEL_RESET;
		end else if (regWr && cfgHit) begin
			chanPinTestSelect  <= regWrData[rtsm_pkg::CHAN_SEL_LSB +: rtsm_pkg::SEL_W];
			framePinTestSelect <= regWrData[rtsm_pkg::FRAME_SEL_LSB +: rtsm_pkg::SEL_W];
		end
	end

	// read data stands one cycle only; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdData <= rtsm_pkg::RD_IDLE;
		end else if (regRd && cfgHit) begin
			regRdData <= {6'h00, framePinTestSelect, chanPinTestSelect};
		end else if (regRd && statHit) begin
			regRdData <= {5'h00, syncClocks, txActive, frameStartOut, clearChannelOut};
		end else begin
			regRdData <= rtsm_pkg::RD_IDLE;
		end
	end

	// ==========================================================
	// channel pin source selection
	always_comb begin
		unique case (chanPinTestSelect)
			// RULE1 normal indication
			rtsm_pkg::SEL_NORMAL: next_clearChannelOut = clearChannelNormal;
			// RULE2 ADC Q lsb
			rtsm_pkg::SEL_ADC_LSB: next_clearChannelOut = adcQLsb;
			// RULE4 late resync pulse
			rtsm_pkg::SEL_RESYNC: next_clearChannelOut = pulseA;
			// RULE7 chip and bit clocks
			rtsm_pkg::SEL_TX_FAST: next_clearChannelOut =
				txActive & syncClocks[rtsm_pkg::SYNC_CHIP_CLK];
			rtsm_pkg::SEL_TX_SLOW: next_clearChannelOut =
				txActive & syncClocks[rtsm_pkg::SYNC_BIT_CLK];
			// RULE10 gain update pulse
			rtsm_pkg::SEL_C12: next_clearChannelOut = gainUpdatePulse;
			// RULE11 peaks and gain bits
			rtsm_pkg::SEL_C13: next_clearChannelOut = peakDetect[1];
			rtsm_pkg::SEL_C14: next_clearChannelOut = peakDetect[3];
			rtsm_pkg::SEL_C15: next_clearChannelOut = gainMode[1];
			rtsm_pkg::SEL_C16: next_clearChannelOut = vgaGain[1];
			// RULE13 peak reset, low active
			rtsm_pkg::SEL_C17: next_clearChannelOut = vgaPeakReset_n;
			// RULE15 8 MHz clock
			rtsm_pkg::SEL_CLK8: next_clearChannelOut = syncClocks[rtsm_pkg::SYNC_CLK8];
			// RULE16 crystal stable
			rtsm_pkg::SEL_C24: next_clearChannelOut = crystalStable;
			// RULE20 first ADC clock
			rtsm_pkg::SEL_ADC_CLK: next_clearChannelOut = syncClocks[rtsm_pkg::SYNC_ADC_ONE];
			// RULE21 reserved codes fall to low
			default: next_clearChannelOut = commonSource(chanPinTestSelect, syncClocks);
		endcase
	end

	// ==========================================================
	// frame pin source selection
	always_comb begin
		unique case (framePinTestSelect)
			// RULE1 normal indication
			rtsm_pkg::SEL_NORMAL: next_frameStartOut = frameStartNormal;
			// RULE3 ADC I lsb
			rtsm_pkg::SEL_ADC_LSB: next_frameStartOut = adcILsb;
			// RULE5 early resync pulse
			rtsm_pkg::SEL_RESYNC: next_frameStartOut = demodResyncEarlyPulse;
			// RULE8 chip and bit data
			rtsm_pkg::SEL_TX_FAST: next_frameStartOut = txActive & txChipData;
			rtsm_pkg::SEL_TX_SLOW: next_frameStartOut = txActive & txBitData;
			// RULE12 peaks and gain bits
			rtsm_pkg::SEL_C12: next_frameStartOut = peakDetect[0];
			rtsm_pkg::SEL_C13: next_frameStartOut = peakDetect[2];
			rtsm_pkg::SEL_C14: next_frameStartOut = peakDetect[4];
			rtsm_pkg::SEL_C15: next_frameStartOut = gainMode[0];
			rtsm_pkg::SEL_C16: next_frameStartOut = vgaGain[0];
			// RULE14 filter calibration clock
			rtsm_pkg::SEL_C17: next_frameStartOut = syncClocks[rtsm_pkg::SYNC_CAL_CLK];
			// RULE17 frequency comparator
			rtsm_pkg::SEL_C24: next_frameStartOut = synthFreqCompare;
			// RULE20 second ADC clock
			rtsm_pkg::SEL_ADC_CLK: next_frameStartOut = syncClocks[rtsm_pkg::SYNC_ADC_TWO];
			// RULE21 reserved codes, including 23, fall to low
			default: next_frameStartOut = commonSource(framePinTestSelect, syncClocks);
		endcase
	end

	// ==========================================================
	// pins are registered so they never glitch while a select changes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clearChannelOut <= 1'b0;
			frameStartOut   <= 1'b0;
		end else begin
			clearChannelOut <= next_clearChannelOut;
			frameStartOut   <= next_frameStartOut;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	adc_q_lsb_a: assert property ( // RULE2
		(chanPinTestSelect == rtsm_pkg::SEL_ADC_LSB) |=> (clearChannelOut == $past(adcQLsb))
	) else $error("channel pin does not follow ADC Q lsb");

	adc_i_lsb_a: assert property ( // RULE3
		(framePinTestSelect == rtsm_pkg::SEL_ADC_LSB) |=> (frameStartOut == $past(adcILsb))
	) else $error("frame pin does not follow ADC I lsb");

	late_resync_pulse_a: assert property ( // RULE4
		(chanPinTestSelect == rtsm_pkg::SEL_RESYNC && pulseA && $past(!pulseA)
			&& $past(chanPinTestSelect) == rtsm_pkg::SEL_RESYNC)
		|=> clearChannelOut ##1 (clearChannelOut == $past(pulseA)
			|| $past(chanPinTestSelect) != rtsm_pkg::SEL_RESYNC)
	) else $error("late resync pulse not mirrored one cycle");

	early_resync_pulse_a: assert property ( // RULE5
		(framePinTestSelect == rtsm_pkg::SEL_RESYNC && !demodResyncEarlyPulse)
		|=> !frameStartOut
	) else $error("frame pin high without early resync event");

	lock_status_a: assert property ( // RULE6
		(chanPinTestSelect == rtsm_pkg::SEL_LOCK && framePinTestSelect == rtsm_pkg::SEL_LOCK)
		|=> (clearChannelOut == frameStartOut) && (frameStartOut == $past(lockStatus))
	) else $error("lock status not on both pins");

	chip_clock_gate_a: assert property ( // RULE7
		(chanPinTestSelect == rtsm_pkg::SEL_TX_FAST)
		|=> (clearChannelOut == ($past(txActive) & $past(syncClocks[rtsm_pkg::SYNC_CHIP_CLK])))
	) else $error("chip clock not gated by transmit");

	tx_bit_data_a: assert property ( // RULE8
		(framePinTestSelect == rtsm_pkg::SEL_TX_SLOW && !txActive) |=> !frameStartOut
	) else $error("bit data shown outside transmission");

	power_down_map_a: assert property ( // RULE9
		(chanPinTestSelect == rtsm_pkg::SEL_PD_LAST) |=> (clearChannelOut == $past(powerDown[5]))
	) else $error("amplifier power-down not on channel pin");

	gain_update_a: assert property ( // RULE10
		(chanPinTestSelect == rtsm_pkg::SEL_C12) |=> (clearChannelOut == $past(gainUpdatePulse))
	) else $error("gain update pulse not mirrored");

	frame_peak_a: assert property ( // RULE12
		(framePinTestSelect == rtsm_pkg::SEL_C14) |=> (frameStartOut == $past(peakDetect[4]))
	) else $error("peak stage 4 not on frame pin");

	constant_levels_a: assert property ( // RULE20
		(chanPinTestSelect == rtsm_pkg::SEL_HIGH && framePinTestSelect == rtsm_pkg::SEL_LOW)
		|=> clearChannelOut && !frameStartOut
	) else $error("constant levels wrong");

	reserved_low_a: assert property ( // RULE21
		(chanPinTestSelect inside {[5'h12:5'h16]}) |=> !clearChannelOut
	) else $error("reserved code drove channel pin high");

	reserved_frame_a: assert property ( // RULE21
		(framePinTestSelect inside {[5'h12:5'h17]}) |=> !frameStartOut
	) else $error("reserved code drove frame pin high");

endmodule

// File: verif/rtsm_src_model.sv
/*
 * Far-side source model: the clocks that reach the test mux from other
 * clock domains, in the synchroniser's lane order.
 * Assumes the mux samples on rising edges at 10 ns past each 20 ns.
 */
`timescale 1ns/10ps
module rtsm_src_model (
	input  wire logic                        txActive, // transmitting, gates tx clocks
	output logic      [rtsm_pkg::SYNC_W-1:0] foreign   // clock lanes, sync index order
);
	// half periods in 10 ns ticks; distinct so the lanes rarely move together
	localparam int HALF [rtsm_pkg::SYNC_W] = '{3, 5, 7, 2, 4, 8, 6, 9};
	int cnt [rtsm_pkg::SYNC_W];

	// ==========================================================
	// edge generator
	// toggles land 3 ns past a tick, clear of every clk edge, so the
	// synchroniser latency seen by the bench is exact, not a coin toss
	initial begin
		foreign = '0;
		for (int i = 0; i < rtsm_pkg::SYNC_W; i++) begin
			cnt[i] = 0;
		end
		#3;
		forever begin
			#10;
			for (int i = 0; i < rtsm_pkg::SYNC_W; i++) begin
				cnt[i] = cnt[i] + 1;
				if (cnt[i] >= HALF[i]) begin
					cnt[i] = 0;
					foreign[i] = ~foreign[i];
				end
			end
			if (!txActive) begin
				foreign[rtsm_pkg::SYNC_CHIP_CLK] = 1'b0;
				foreign[rtsm_pkg::SYNC_BIT_CLK]  = 1'b0;
			end
		end
	end
endmodule

// File: verif/radio_test_signal_mux_tb.sv
/*
 * Self-checking bench for the test signal mux: random sources, a sweep
 * of every select code on both pins, register corners and a mid-run reset.
 * Assumes the far-side clock model and single 50 MHz clock.
 */
`timescale 1ns/10ps
module radio_test_signal_mux_tb;
	logic                          clk, sys_rst, regWr, regRd, monOn;
	logic [rtsm_pkg::ADDR_W-1:0]   regAddr;
	logic [rtsm_pkg::DATA_W-1:0]   regWrData, regRdData;
	logic                          clearChannelNormal, frameStartNormal, adcQLsb, adcILsb;
	logic                          pulseA, demodResyncEarlyPulse, lockStatus, txActive;
	logic                          txChipData, txBitData, gainUpdatePulse, vgaPeakReset_n;
	logic                          crystalStable, synthFreqCompare, synthLockWindow;
	logic                          synthLockWindowSync, clearChannelOut, frameStartOut, eC, eF;
	logic [rtsm_pkg::PD_W-1:0]     powerDown;
	logic [rtsm_pkg::PEAK_W-1:0]   peakDetect;
	logic [1:0]                    gainMode, vgaGain;
	logic [rtsm_pkg::SYNC_W-1:0]   foreign, fPrev1, fPrev2;
	logic [4:0]                    selC, selF;
	int                            miscompares, cmp_count;
	logic [31:0]                   rnd;

	rtsm_src_model model (.txActive(txActive), .foreign(foreign));

	rtsm_mux dut (
		.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.clearChannelNormal(clearChannelNormal), .frameStartNormal(frameStartNormal),
		.adcQLsb(adcQLsb), .adcILsb(adcILsb), .pulseA(pulseA),
		.demodResyncEarlyPulse(demodResyncEarlyPulse), .lockStatus(lockStatus),
		.txActive(txActive), .txChipData(txChipData), .txBitData(txBitData),
		.powerDown(powerDown), .gainUpdatePulse(gainUpdatePulse), .peakDetect(peakDetect),
		.gainMode(gainMode), .vgaGain(vgaGain), .vgaPeakReset_n(vgaPeakReset_n),
		.crystalStable(crystalStable), .synthFreqCompare(synthFreqCompare),
		.synthLockWindow(synthLockWindow), .synthLockWindowSync(synthLockWindowSync),
		.txChipClock(foreign[rtsm_pkg::SYNC_CHIP_CLK]),
		.txBitClock(foreign[rtsm_pkg::SYNC_BIT_CLK]),
		.rxFilterCalClock(foreign[rtsm_pkg::SYNC_CAL_CLK]),
		.clock8mhz(foreign[rtsm_pkg::SYNC_CLK8]), .synthRef4mhz(foreign[rtsm_pkg::SYNC_REF]),
		.synthDiv4mhz(foreign[rtsm_pkg::SYNC_DIV]),
		.adcClockOne(foreign[rtsm_pkg::SYNC_ADC_ONE]),
		.adcClockTwo(foreign[rtsm_pkg::SYNC_ADC_TWO]),
		.clearChannelOut(clearChannelOut), .frameStartOut(frameStartOut)
	);

	// ==========================================================
	// clock and random sources
	always #10 clk = ~clk;

	// event inputs never stay high two cycles, as the radio guarantees
	always @(posedge clk) begin
		rnd = $urandom;
		{frameStartNormal, clearChannelNormal, adcILsb, adcQLsb} <= rnd[3:0];
		{txBitData, txChipData, lockStatus} <= rnd[6:4];
		powerDown      <= rnd[12:7];
		peakDetect     <= rnd[17:13];
		{vgaGain, gainMode} <= rnd[21:18];
		{synthLockWindowSync, synthLockWindow, synthFreqCompare} <= rnd[26:24];
		{crystalStable, vgaPeakReset_n} <= rnd[23:22];
		pulseA <= !pulseA && rnd[27];
		demodResyncEarlyPulse <= !demodResyncEarlyPulse && rnd[28];
		gainUpdatePulse <= !gainUpdatePulse && rnd[29];
		if (rnd[31:30] == 2'h0 && $urandom_range(7) == 0) begin
			txActive <= ~txActive;
		end
	end

	// ==========================================================
	// expected pin levels; foreign lanes are two cycles late
	function automatic logic expChan(input logic [4:0] s);
		case (s)
			5'h00: expChan = clearChannelNormal;
			5'h01: expChan = adcQLsb;
			5'h02: expChan = pulseA;
			5'h03: expChan = lockStatus;
			5'h04: expChan = txActive & fPrev2[rtsm_pkg::SYNC_CHIP_CLK];
			5'h05: expChan = txActive & fPrev2[rtsm_pkg::SYNC_BIT_CLK];
			5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B: expChan = powerDown[s - 5'h06];
			5'h0C: expChan = gainUpdatePulse;
			5'h0D: expChan = peakDetect[1];
			5'h0E: expChan = peakDetect[3];
			5'h0F: expChan = gainMode[1];
			5'h10: expChan = vgaGain[1];
			5'h11: expChan = vgaPeakReset_n;
			5'h17: expChan = fPrev2[rtsm_pkg::SYNC_CLK8];
			5'h18: expChan = crystalStable;
			5'h19: expChan = fPrev2[rtsm_pkg::SYNC_REF];
			5'h1A: expChan = fPrev2[rtsm_pkg::SYNC_DIV];
			5'h1B: expChan = synthLockWindow;
			5'h1C: expChan = synthLockWindowSync;
			5'h1D: expChan = fPrev2[rtsm_pkg::SYNC_ADC_ONE];
			5'h1F: expChan = 1'b1;
			default: expChan = 1'b0;
		endcase
	endfunction

	function automatic logic expFrame(input logic [4:0] s);
		case (s)
			5'h00: expFrame = frameStartNormal;
			5'h01: expFrame = adcILsb;
			5'h02: expFrame = demodResyncEarlyPulse;
			5'h03: expFrame = lockStatus;
			5'h04: expFrame = txActive & txChipData;
			5'h05: expFrame = txActive & txBitData;
			5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B: expFrame = powerDown[s - 5'h06];
			5'h0C: expFrame = peakDetect[0];
			5'h0D: expFrame = peakDetect[2];
			5'h0E: expFrame = peakDetect[4];
			5'h0F: expFrame = gainMode[0];
			5'h10: expFrame = vgaGain[0];
			5'h11: expFrame = fPrev2[rtsm_pkg::SYNC_CAL_CLK];
			5'h18: expFrame = synthFreqCompare;
			5'h19: expFrame = fPrev2[rtsm_pkg::SYNC_REF];
			5'h1A: expFrame = fPrev2[rtsm_pkg::SYNC_DIV];
			5'h1B: expFrame = synthLockWindow;
			5'h1C: expFrame = synthLockWindowSync;
			5'h1D: expFrame = fPrev2[rtsm_pkg::SYNC_ADC_TWO];
			5'h1F: expFrame = 1'b1;
			default: expFrame = 1'b0;
		endcase
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ==========================================================
	// pin monitor: shadows the selects from the bus, checks every cycle
	always @(posedge clk) begin
		eC = sys_rst ? 1'b0 : expChan(selC);
		eF = sys_rst ? 1'b0 : expFrame(selF);
		if (sys_rst) begin
			{selC, selF, fPrev1, fPrev2} <= '0;
		end else begin
			if (regWr && regAddr == rtsm_pkg::REG_PIN_CFG) begin
				{selF, selC} <= regWrData[9:0];
			end
			fPrev2 <= fPrev1;
			fPrev1 <= foreign;
		end
		#1;
		if (monOn) begin
			check("channel pin", {15'h0000, eC}, {15'h0000, clearChannelOut});
			check("frame pin", {15'h0000, eF}, {15'h0000, frameStartOut});
		end
	end

	task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic regRead(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// watchdog: the tests need about 3300 cycles
	initial begin
		#400000;
		miscompares++;
		$display("watchdog expired");
		tally_and_finish();
	end

	// ==========================================================
	// main sequence
	initial begin
		logic [15:0] d;
		logic [4:0]  a, b;
		{clk, regWr, regRd, monOn, regAddr, regWrData} = '0;
		{clearChannelNormal, frameStartNormal, adcQLsb, adcILsb, pulseA, lockStatus} = '0;
		{demodResyncEarlyPulse, txActive, txChipData, txBitData, gainUpdatePulse} = '0;
		{powerDown, peakDetect, gainMode, vgaGain, vgaPeakReset_n, crystalStable} = '0;
		{synthFreqCompare, synthLockWindow, synthLockWindowSync} = '0;
		{miscompares, cmp_count} = '0;
		sys_rst = 1'b1;
		void'($urandom(72314));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		monOn = 1'b1;
		regRead(rtsm_pkg::REG_PIN_CFG, d);
		check("config after reset", 16'h0000, d);
		$display("test reset_values done");
		// every code on both pins, each long enough for slow foreign lanes
		for (int c = 0; c < 32; c++) begin
			a = c[4:0];
			b = a + 5'h07;
			regWrite(rtsm_pkg::REG_PIN_CFG, {6'h00, b, a});
			regRead(rtsm_pkg::REG_PIN_CFG, d);
			check("config readback", {6'h00, b, a}, d);
			repeat (60) @(posedge clk);
		end
		$display("test code_sweep done");
		for (int n = 0; n < 100; n++) begin
			regWrite(rtsm_pkg::REG_PIN_CFG, 16'($urandom));
			repeat ($urandom_range(20)) @(posedge clk);
		end
		$display("test random_selects done");
		// constant codes, then writes that must not land anywhere
		regWrite(rtsm_pkg::REG_PIN_CFG, {6'h00, 5'h1E, 5'h1F});
		regWrite(rtsm_pkg::REG_PIN_STAT, 16'hFFFF);
		regWrite(8'h08, 16'h03FF);
		regRead(rtsm_pkg::REG_PIN_CFG, d);
		check("config kept", 16'h03DF, d);
		regRead(rtsm_pkg::REG_PIN_STAT, d);
		check("status pins", 16'h0001, d & 16'hF803);
		@(posedge clk);
		#1 check("read data idle", 16'h0000, regRdData);
		regRead(8'h02, d);
		check("unmapped read", 16'h0000, d);
		regRead(8'hFF, d);
		check("unmapped read", 16'h0000, d);
		$display("test register_corners done");
		regWrite(rtsm_pkg::REG_PIN_CFG, 16'h0063);
		repeat (5) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		regRead(rtsm_pkg::REG_PIN_CFG, d);
		check("config after second reset", 16'h0000, d);
		repeat (20) @(posedge clk);
		$display("test mid_reset done");
		tally_and_finish();
	end
endmodule
